// ### verilog/reset_cause_pkg.sv
// constants for the reset cause and reset sequencing unit
// assumes a 32-bit apb master and a 25 mhz pclk
package reset_cause_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [31:0] ADDR_PROT_CMD = 32'hffff_f880;
	localparam logic [31:0] ADDR_DEBUG_CTRL = 32'hffff_f884;
	localparam logic [31:0] ADDR_RESET_CAUSE = 32'hffff_f888;
	localparam logic [31:0] ADDR_EVENT_STATUS = 32'hffff_f88c;
	localparam logic [31:0] ADDR_EVENT_MASK = 32'hffff_f890;

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int BIT_LOW_VOLTAGE = 0;
	localparam int BIT_CLOCK_MONITOR = 1;
	localparam int BIT_WATCHDOG = 4;
	localparam int BIT_DEBUG_ENTRY = 5;
	localparam int BIT_RAM_COLLIDE = 6;
	localparam logic [7:0] CAUSE_VALID_MASK = 8'h13;
	localparam logic [7:0] EVENT_VALID_MASK = 8'h73;
	localparam logic [7:0] CAUSE_RESET = 8'h00;
	localparam logic [7:0] DEBUG_CTRL_RESET = 8'h01;
	localparam logic [7:0] EVENT_RESET = 8'h00;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int OSC_STAB_NS = 100000;
	localparam int OSC_STAB_CYCLES = (OSC_STAB_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		st_hold = 2'b00,
		st_stab = 2'b01,
		st_run = 2'b10
	} seq_state_t;

endpackage

// ### verilog/reset_cause_unit.sv
// reset cause record, reset sequencing and debug arming, apb slave
// assumes presetn is the external reset pin and inputs are synchronous
//
// Summary of operation
// R1: cause register written only after protect command
// R2: byte writes; bit writes via read-modify-write
// R3: reset pin clears cause register to zero
// R4: flags at bits 4, 1, 0; others zero
// R5: flag one means source caused reset
// R6: each internal reset sets its flag
// R7: other flags keep value on internal reset
// R8: writing zero clears, writing one keeps
// R9: hardware set wins over software clear
// R10: pin low holds whole system in reset
// R11: pin rising edge releases reset
// R12: main, internal oscillators stop; subclock runs
// R13: clocks enabled after stabilisation interval
// R14: cpu runs only after stabilisation interval
// R15: watchdog counter zero in reset, counts after
// R16: pin reset sets debug control to 01h
// R17: ram kept; collision with reset flagged
// R18: debug pin high with bit set enters debug
// R19: internal reset requests latched through reset
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module reset_cause_unit
	import reset_cause_pkg::*;
#(
	parameter int STAB_CYCLES = OSC_STAB_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic watchdog_reset_req,
	input wire logic low_voltage_reset_req,
	input wire logic clock_monitor_reset_req,
	input wire logic debug_reset_pin,
	input wire logic cpu_ram_access,
	output logic main_osc_en,
	output logic int_osc_en,
	output logic sub_osc_en,
	output logic periph_clk_en,
	output logic cpu_clk_en,
	output logic cpu_reset_n,
	output logic io_hiz,
	output logic [15:0] watchdog_count,
	output logic debug_mode,
	output logic irq
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	seq_state_t state;
	seq_state_t next_state;
	logic [15:0] stab_count;
	logic [7:0] reset_cause_flags;
	logic [7:0] debug_mode_control;
	logic [7:0] event_status;
	logic [7:0] event_mask;
	logic prot_armed;

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
		hit = (a == r);
	endfunction

	wire sel_prot = hit(paddr, ADDR_PROT_CMD);
	wire sel_debug = hit(paddr, ADDR_DEBUG_CTRL);
	wire sel_cause = hit(paddr, ADDR_RESET_CAUSE);
	wire sel_status = hit(paddr, ADDR_EVENT_STATUS);
	wire sel_mask = hit(paddr, ADDR_EVENT_MASK);
	wire mapped = sel_prot | sel_debug | sel_cause | sel_status | sel_mask;
	wire access = psel & penable;
	wire done = access & pready;
	// R2: byte lane strobe
	wire wr_go = done & pwrite & mapped & pstrb[0];
	wire [7:0] wbyte = pwdata[7:0];

	// R1: protect gate
	wire cause_wr = wr_go & sel_cause & prot_armed;
	// R8: zero-write clear
	wire [7:0] cause_clr = cause_wr ? (~wbyte & CAUSE_VALID_MASK) : 8'h00;

	// R5: one marks fired source
	// R6: internal reset sets
	wire [7:0] cause_set = ({7'h00, low_voltage_reset_req} << BIT_LOW_VOLTAGE)
		| ({7'h00, clock_monitor_reset_req} << BIT_CLOCK_MONITOR)
		| ({7'h00, watchdog_reset_req} << BIT_WATCHDOG);
	wire any_req = low_voltage_reset_req | clock_monitor_reset_req |
		watchdog_reset_req;

	// R9: set wins over clear
	// R7: other flags kept
	wire [7:0] next_cause = ((reset_cause_flags & ~cause_clr) | cause_set)
		& CAUSE_VALID_MASK;

	wire debug_entry = debug_mode_control[0] & debug_reset_pin &
		(state != st_hold) & ~debug_mode;
	// R17: ram collision record
	wire ram_collide = any_req & (state != st_hold) & cpu_ram_access;
	wire [7:0] event_set = cause_set | ({7'h00, debug_entry} << BIT_DEBUG_ENTRY)
		| ({7'h00, ram_collide} << BIT_RAM_COLLIDE);
	wire [7:0] event_clr = (wr_go & sel_status) ? wbyte : 8'h00;
	wire [7:0] next_event = ((event_status & ~event_clr) | event_set)
		& EVENT_VALID_MASK;

	// R4: reserved bits read zero
	wire [7:0] rd_byte = sel_cause ? reset_cause_flags :
		sel_debug ? debug_mode_control :
		sel_status ? event_status :
		sel_mask ? event_mask : 8'h00;

	// ---------------------------------------------------------------
	// apb response, one wait state
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access & ~pready;
			pslverr <= access & ~pready & ~mapped;
			prdata <= (access & ~pready & ~pwrite) ? {24'h00_0000, rd_byte} :
				32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// R1: arm on protect command, any other write disarms
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prot_armed <= 1'b0;
		end else if (done & pwrite) begin
			prot_armed <= sel_prot;
		end
	end

	// R3: pin reset clears record
	// R19: requests latched while held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_cause_flags <= CAUSE_RESET;
		end else begin
			reset_cause_flags <= next_cause;
		end
	end

	// R16: pin reset loads 01h, kept over internal resets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			debug_mode_control <= DEBUG_CTRL_RESET;
		end else if (wr_go & sel_debug) begin
			debug_mode_control <= wbyte & 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_status <= EVENT_RESET;
			event_mask <= EVENT_RESET;
			irq <= 1'b0;
		end else begin
			event_status <= next_event;
			if (wr_go & sel_mask) begin
				event_mask <= wbyte & EVENT_VALID_MASK;
			end
			irq <= |(next_event & event_mask);
		end
	end

	// R18: debug entry sticky until pin reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			debug_mode <= 1'b0;
		end else if (debug_entry) begin
			debug_mode <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// reset sequencer
	// ---------------------------------------------------------------
	wire stab_done = (stab_count == 16'(STAB_CYCLES - 1));

	always_comb begin
		next_state = state;
		unique case (state)
			st_hold: begin
				if (!any_req) begin
					next_state = st_stab;
				end
			end
			st_stab: begin
				if (any_req) begin
					next_state = st_hold;
				end else if (stab_done) begin
					next_state = st_run;
				end
			end
			st_run: begin
				if (any_req) begin
					next_state = st_hold;
				end
			end
			default: begin
				next_state = st_hold;
			end
		endcase
	end

	// R10: pin low forces every output to reset
	// R11: release starts stabilisation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_stab;
			stab_count <= 16'h0000;
		end else begin
			state <= next_state;
			stab_count <= (next_state == st_stab && state == st_stab) ?
				stab_count + 16'h0001 : 16'h0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_osc_en <= 1'b0;
			int_osc_en <= 1'b0;
			sub_osc_en <= 1'b1;
			periph_clk_en <= 1'b0;
			cpu_clk_en <= 1'b0;
			cpu_reset_n <= 1'b0;
			io_hiz <= 1'b1;
		end else begin
			// R12: oscillators stop in reset, subclock runs
			main_osc_en <= (next_state != st_hold);
			int_osc_en <= (next_state != st_hold);
			sub_osc_en <= 1'b1;
			// R13: clocks after stabilisation
			periph_clk_en <= (next_state == st_run);
			cpu_clk_en <= (next_state == st_run);
			// R14: cpu released after stabilisation
			cpu_reset_n <= (next_state == st_run);
			io_hiz <= (next_state != st_run);
		end
	end

	// R15: watchdog counter cleared in reset, counts on internal osc
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_count <= 16'h0000;
		end else if (next_state == st_hold) begin
			watchdog_count <= 16'h0000;
		end else if (int_osc_en) begin
			watchdog_count <= watchdog_count + 16'h0001;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_prot;
		(wr_go & sel_cause & ~prot_armed & ~any_req) |=>
			reset_cause_flags == $past(reset_cause_flags);
	endproperty
	a_prot: assert property (p_prot) else $error("unprotected write took"); // R1

	property p_reserved;
		(reset_cause_flags & ~CAUSE_VALID_MASK) == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set"); // R4

	property p_set;
		watchdog_reset_req |=> reset_cause_flags[BIT_WATCHDOG];
	endproperty
	a_set: assert property (p_set) else $error("watchdog flag not set"); // R6

	property p_keep;
		(low_voltage_reset_req & ~cause_wr) |=>
			reset_cause_flags[BIT_CLOCK_MONITOR] ==
			$past(reset_cause_flags[BIT_CLOCK_MONITOR]);
	endproperty
	a_keep: assert property (p_keep) else $error("other flag lost"); // R7

	property p_clear;
		(cause_wr & ~wbyte[BIT_LOW_VOLTAGE] & ~low_voltage_reset_req) |=>
			~reset_cause_flags[BIT_LOW_VOLTAGE];
	endproperty
	a_clear: assert property (p_clear) else $error("zero write kept flag"); // R8

	property p_priority;
		(cause_wr & ~wbyte[BIT_CLOCK_MONITOR] & clock_monitor_reset_req) |=>
			reset_cause_flags[BIT_CLOCK_MONITOR];
	endproperty
	a_priority: assert property (p_priority) else $error("clear beat set"); // R9

	property p_osc;
		any_req |=> ~main_osc_en & ~int_osc_en & sub_osc_en;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator not stopped"); // R12

	property p_stab;
		(state == st_hold && next_state == st_stab) |=>
			~cpu_clk_en [*2];
	endproperty
	a_stab: assert property (p_stab) else $error("clock before stab"); // R13

	property p_cpu;
		$rose(cpu_reset_n) |-> $past(stab_done) && cpu_clk_en;
	endproperty
	a_cpu: assert property (p_cpu) else $error("cpu released early"); // R14

	property p_wdt;
		(state == st_hold) |=> watchdog_count == 16'h0000 ||
			$past(next_state) != st_hold;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog not cleared"); // R15

	property p_debug;
		(debug_mode_control[0] & debug_reset_pin & state != st_hold) |=>
			debug_mode;
	endproperty
	a_debug: assert property (p_debug) else $error("debug not entered"); // R18

	property p_rdres;
		(pready && $past(sel_cause && !pwrite)) |->
			(prdata[7:0] & ~CAUSE_VALID_MASK) == 8'h00;
	endproperty
	a_rdres: assert property (p_rdres) else $error("reserved read"); // R4

	property p_wcnt;
		(state == st_run && $past(state) == st_run) |->
			watchdog_count == $past(watchdog_count) + 16'h0001;
	endproperty
	a_wcnt: assert property (p_wcnt) else $error("watchdog stalled"); // R15

	property p_ram;
		(any_req && state != st_hold && cpu_ram_access) |=>
			event_status[BIT_RAM_COLLIDE];
	endproperty
	a_ram: assert property (p_ram) else $error("ram collision lost"); // R17

	property p_clkoff;
		(state == st_hold) |=>
			!periph_clk_en && !cpu_clk_en && io_hiz;
	endproperty
	a_clkoff: assert property (p_clkoff) else $error("clock in hold"); // R13

	property p_dbgkeep;
		(any_req && !(wr_go && sel_debug)) |=>
			debug_mode_control == $past(debug_mode_control);
	endproperty
	a_dbgkeep: assert property (p_dbgkeep) else $error("debug ctrl lost"); // R16

	c_wdt_reset: cover property (watchdog_reset_req ##1 state == st_hold);
	c_release: cover property ($rose(cpu_reset_n));
	c_clear: cover property (cause_wr && wbyte == 8'h00);
	c_debug: cover property ($rose(debug_mode));

endmodule

`default_nettype wire

// ### test/ext_reset_src.sv
// external reset pin source model
// assumes pclk from the bench; pin starts low at power-up
`timescale 1ns/1ps
`default_nettype none

module ext_reset_src (
	input wire logic pclk,
	input wire logic assert_req,
	output var logic presetn
);
	logic [2:0] cnt = 3'd5;

	initial presetn = 1'b0;

	// pin held low five edges per request
	always @(posedge pclk) begin
		if (assert_req) begin
			cnt <= 3'd5;
		end else if (cnt != 3'd0) begin
			cnt <= cnt - 3'd1;
		end
		presetn <= !(assert_req || cnt > 3'd1);
	end
endmodule

`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the reset cause unit
// assumes a small STAB_CYCLES and the unit's one-wait-state apb slave
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import reset_cause_pkg::*;
	localparam int STAB = 4;
	logic pclk = 1'b0;
	logic presetn, pready, pslverr, irq, ev;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0, prdata;
	logic [2:0] req = 3'b000;
	logic dbg_pin = 1'b0, ram_acc = 1'b0, pin_req = 1'b0;
	logic main_osc_en, int_osc_en, sub_osc_en, periph_clk_en, cpu_clk_en;
	logic cpu_reset_n, io_hiz, debug_mode;
	logic [15:0] watchdog_count;
	logic [7:0] rv, d;
	int miscompares = 0;
	int n_tests = 0;

	always #20 pclk = ~pclk;

	ext_reset_src src_u (.pclk(pclk), .assert_req(pin_req), .presetn(presetn));

	reset_cause_unit #(.STAB_CYCLES(STAB)) dut_u (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .watchdog_reset_req(req[2]),
		.low_voltage_reset_req(req[0]), .clock_monitor_reset_req(req[1]),
		.debug_reset_pin(dbg_pin), .cpu_ram_access(ram_acc),
		.main_osc_en(main_osc_en), .int_osc_en(int_osc_en),
		.sub_osc_en(sub_osc_en), .periph_clk_en(periph_clk_en),
		.cpu_clk_en(cpu_clk_en), .cpu_reset_n(cpu_reset_n), .io_hiz(io_hiz),
		.watchdog_count(watchdog_count), .debug_mode(debug_mode), .irq(irq));

	function automatic logic [7:0] pins();
		return {main_osc_en, int_osc_en, sub_osc_en, periph_clk_en,
			cpu_clk_en, cpu_reset_n, io_hiz, watchdog_count == 16'h0000};
	endfunction

	function automatic logic [7:0] cause_exp(logic [7:0] o, logic [7:0] w);
		return o & w & CAUSE_VALID_MASK;
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [31:0] a,
		input logic [7:0] dv);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0000_00, dv};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) miscompares++;
		rv = prdata[7:0];
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [7:0] e,
		input string nm);
		apb(1'b0, a, 8'h00);
		chk(nm, e, rv);
	endtask

	task automatic wait_run();
		int n;
		n = 0;
		repeat (3) @(posedge pclk);
		while (cpu_reset_n !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (cpu_reset_n !== 1'b1) miscompares++;
		#1;
	endtask

	task automatic fire(input logic [2:0] m);
		@(posedge pclk);
		req <= m;
		@(posedge pclk);
		req <= 3'b000;
		wait_run();
	endtask

	task automatic boot();
		int n;
		n = 0;
		chk("hold_vec", 8'h23, pins());
		wait (presetn === 1'b1);
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (cpu_reset_n !== 1'b1 && n < 50);
		chk("stab_len", 8'(STAB), 8'(n));
		chk("run_vec", 8'hfc, pins());
		chk("dbg_mode", 8'h00, {7'h00, debug_mode});
		rd(ADDR_RESET_CAUSE, CAUSE_RESET, "cause");
		rd(ADDR_DEBUG_CTRL, DEBUG_CTRL_RESET, "dbg_ctrl");
	endtask

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		final_report();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(33));
		@(posedge pclk);
		#1;
		boot();
		apb(1'b0, ADDR_EVENT_MASK + 32'h0000_0010, 8'h00);
		chk("slverr", 8'h01, {7'h00, ev});
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			apb(1'b1, ADDR_EVENT_MASK, d);
			rd(ADDR_EVENT_MASK, d & EVENT_VALID_MASK, "mask");
		end
		apb(1'b1, ADDR_EVENT_MASK, 8'h73);
		ram_acc <= 1'b1;
		fire(3'b100);
		ram_acc <= 1'b0;
		rd(ADDR_RESET_CAUSE, 8'h10, "cause");
		fire(3'b010);
		rd(ADDR_RESET_CAUSE, 8'h12, "cause");
		fire(3'b001);
		rd(ADDR_RESET_CAUSE, 8'h13, "cause");
		rd(ADDR_EVENT_STATUS, 8'h53, "status");
		chk("irq", 8'h01, {7'h00, irq});
		apb(1'b1, ADDR_EVENT_MASK, 8'h00);
		@(posedge pclk);
		#1;
		chk("irq", 8'h00, {7'h00, irq});
		apb(1'b1, ADDR_EVENT_MASK, 8'h73);
		apb(1'b1, ADDR_EVENT_STATUS, 8'h53);
		@(posedge pclk);
		#1;
		chk("irq", 8'h00, {7'h00, irq});
		rd(ADDR_EVENT_STATUS, 8'h00, "status");
		apb(1'b1, ADDR_RESET_CAUSE, 8'h00);
		rd(ADDR_RESET_CAUSE, 8'h13, "cause");
		apb(1'b1, ADDR_PROT_CMD, 8'h00);
		rd(ADDR_DEBUG_CTRL, 8'h01, "dbg_ctrl");
		apb(1'b1, ADDR_RESET_CAUSE, 8'hee);
		rd(ADDR_RESET_CAUSE, cause_exp(8'h13, 8'hee), "cause");
		apb(1'b1, ADDR_PROT_CMD, 8'h00);
		apb(1'b1, ADDR_RESET_CAUSE, 8'hff);
		rd(ADDR_RESET_CAUSE, 8'h02, "cause");
		apb(1'b1, ADDR_PROT_CMD, 8'h00);
		req <= 3'b011;
		apb(1'b1, ADDR_RESET_CAUSE, 8'h00);
		req <= 3'b000;
		wait_run();
		rd(ADDR_RESET_CAUSE, 8'h03, "cause");
		dbg_pin <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
		chk("dbg_mode", 8'h01, {7'h00, debug_mode});
		@(posedge pclk);
		dbg_pin <= 1'b0;
		pin_req <= 1'b1;
		@(posedge pclk);
		pin_req <= 1'b0;
		#1;
		boot();
		apb(1'b1, ADDR_DEBUG_CTRL, 8'h00);
		dbg_pin <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
		chk("dbg_mode", 8'h00, {7'h00, debug_mode});
		final_report();
	end
endmodule

`default_nettype wire
